// *** verilog/pcrs_pkg.sv ***
/*
 Package for the program counter and return stack block: register map,
 field positions, reset values and sequencer command codes.
 Assumes a 32-bit Avalon-MM slave with word-aligned registers.
*/
`default_nettype none
package pcrs_pkg;
   // ==========================================================
   // Widths
   localparam int PC_W    = 21;
   localparam int LVL_W   = 5;
   localparam int DEPTH   = 31;
   // ==========================================================
   // Register byte offsets
   localparam logic [5:0] OFS_LOW   = 6'h00;
   localparam logic [5:0] OFS_HLAT  = 6'h04;
   localparam logic [5:0] OFS_ULAT  = 6'h08;
   localparam logic [5:0] OFS_PTR   = 6'h0C;
   localparam logic [5:0] OFS_TOP_ENTRY_LOW  = 6'h10;
   localparam logic [5:0] OFS_TOP_ENTRY_HIGH  = 6'h14;
   localparam logic [5:0] OFS_TOP_ENTRY_UPPER  = 6'h18;
   localparam logic [5:0] OFS_PCRD  = 6'h1C;
   // ==========================================================
   // Pointer register fields
   localparam int BIT_FULL  = 7;
   localparam int BIT_UNF   = 6;
   localparam int UPPER_W   = 5;
   localparam logic [LVL_W-1:0] LVL_EMPTY = 5'h00;
   localparam logic [LVL_W-1:0] LVL_TOP   = 5'h1F;
   localparam logic [PC_W-1:0]  PC_RESET  = 21'h00_0000;
   localparam logic [PC_W-1:0]  PC_STEP   = 21'h00_0002;
   localparam logic [31:0]      RD_ZERO   = 32'h0000_0000;
   // ==========================================================
   // Sequencer commands
   typedef enum logic [7:0] {
      CMD_NONE   = 8'b0000_0001,
      CMD_STEP   = 8'b0000_0010,
      CMD_JUMP   = 8'b0000_0100,
      CMD_CALL   = 8'b0000_1000,
      CMD_RET    = 8'b0001_0000,
      CMD_ULNK   = 8'b0010_0000,
      CMD_PUSH   = 8'b0100_0000,
      CMD_POP    = 8'b1000_0000
   } pcrs_cmd_t;
endpackage : pcrs_pkg
`default_nettype wire

// *** verilog/pcrs_core.sv ***
/*
 Program counter with byte latches and a 31-entry hardware return stack.
 Assumes the sequencer issues one command per cycle and that register
 bus accesses and sequencer commands to the same state are not overlapped
 by software (interrupts disabled while touching the stack).
*/
// Local design decisions: the register addresses and the Avalon-MM interface to the registers.
// Summary of operation
// R1: Counter is 21 bits in low, high and upper byte parts.
// R2: Low byte is read/write; high byte loads only from high latch.
// R3: Upper bits 20..16 load only from the upper latch.
// R4: Writing the low byte copies both latches into the counter.
// R5: Reading the low byte copies counter high/upper into latches.
// R6: Bit zero is always zero; sequential step adds two.
// R7: Calls, gotos and branches load counter directly, ignoring latches.
// R8: Calls and interrupts push; returns and enabled unlinks pop.
// R9: Calls and returns leave both latches unchanged.
// R10: Stack is 31 words of 21 bits with 5-bit pointer.
// R11: Push increments the pointer, then writes the return address.
// R12: Pop loads counter from selected entry, then decrements pointer.
// R13: Pointer is zero after every reset.
// R14: Pointer value zero has no storage behind it.
// R15: Three top registers read and write the selected entry.
// R16: Software reads and writes pointer, range 0 to 31.
// R17: Full flag sets on the 31st push, cleared by software or reset.
// R18: With overflow reset, 31st push stores PC+2, resets, keeps flag.
// R19: Without overflow reset, pointer stays 31 and entry 31 holds.
// R20: Empty pop loads zero, sets underflow, pointer stays zero.
// R21: Underflow zero load is not a reset; registers stay.
// R22: Push instruction stores counter; pop instruction only decrements.
// R23: Pointer register: full bit7, underflow bit6, bit5 zero, level 4..0.
`timescale 1ns/100ps
`default_nettype none
module pcrs_core #(
   parameter int DEPTH = pcrs_pkg::DEPTH
) (
   input  wire logic                     clk_in,
   input  wire logic                     reset_n_in,
   input  wire logic                     overflow_reset_enable_in,
   input  wire logic                     ext_set_in,
   input  wire pcrs_pkg::pcrs_cmd_t      cmd_in,
   input  wire logic [pcrs_pkg::PC_W-1:0] target_in,
   input  wire logic [5:0]               avs_address_in,
   input  wire logic                     avs_read_in,
   input  wire logic                     avs_write_in,
   input  wire logic [31:0]              avs_writedata_in,
   output logic [31:0]                   avs_readdata_out,
   output logic                          avs_waitrequest_out,
   output logic [pcrs_pkg::PC_W-1:0]     pc_out,
   output logic                          overflow_reset_out,
   output logic                          stack_full_flag_out,
   output logic                          stack_underflow_flag_out
);
   // ==========================================================
   // State
   logic [pcrs_pkg::PC_W-1:0]  pc;
   logic [7:0]                 counter_high_latch;
   logic [pcrs_pkg::UPPER_W-1:0] counter_upper_latch;
   logic [pcrs_pkg::LVL_W-1:0] stack_level;
   logic                       stack_full_flag;
   logic                       stack_underflow_flag;
   logic [pcrs_pkg::PC_W-1:0]  stack_mem [1:DEPTH];
   logic                       ack;

   // ==========================================================
   // Bus decode; one wait cycle then acknowledge
   logic bus_req;
   logic wr_low, rd_low, wr_ptr, wr_tos_l, wr_tos_h, wr_tos_u, wr_hlat, wr_ulat;
   assign bus_req  = (avs_read_in | avs_write_in) & ~ack;
   assign wr_low   = bus_req & avs_write_in & (avs_address_in == pcrs_pkg::OFS_LOW);
   assign rd_low   = bus_req & avs_read_in & (avs_address_in == pcrs_pkg::OFS_LOW);
   assign wr_ptr   = bus_req & avs_write_in & (avs_address_in == pcrs_pkg::OFS_PTR);
   assign wr_hlat  = bus_req & avs_write_in & (avs_address_in == pcrs_pkg::OFS_HLAT);
   assign wr_ulat  = bus_req & avs_write_in & (avs_address_in == pcrs_pkg::OFS_ULAT);
   assign wr_tos_l = bus_req & avs_write_in & (avs_address_in == pcrs_pkg::OFS_TOP_ENTRY_LOW);
   assign wr_tos_h = bus_req & avs_write_in & (avs_address_in == pcrs_pkg::OFS_TOP_ENTRY_HIGH);
   assign wr_tos_u = bus_req & avs_write_in & (avs_address_in == pcrs_pkg::OFS_TOP_ENTRY_UPPER);

   // Command classes
   logic is_push, is_pop, stack_empty, at_top, overflow_hit;
   assign is_push     = (cmd_in == pcrs_pkg::CMD_CALL) | (cmd_in == pcrs_pkg::CMD_PUSH); // R8
   assign is_pop      = (cmd_in == pcrs_pkg::CMD_RET) | (cmd_in == pcrs_pkg::CMD_POP)
                      | ((cmd_in == pcrs_pkg::CMD_ULNK) & ext_set_in); // R8
   assign stack_empty = (stack_level == pcrs_pkg::LVL_EMPTY); // R14
   assign at_top      = (stack_level == pcrs_pkg::LVL_TOP);
   // 30 entries in use plus this push makes the 31st
   assign overflow_hit = is_push & (stack_level == pcrs_pkg::LVL_TOP - 5'h01);

   logic [pcrs_pkg::PC_W-1:0] ret_addr, tos_val;
   assign ret_addr = pc + pcrs_pkg::PC_STEP; // R11
   assign tos_val  = stack_empty ? pcrs_pkg::PC_RESET : stack_mem[stack_level];

   // ==========================================================
   // Bus handshake
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ack                 <= 1'b0;
         avs_waitrequest_out <= 1'b1;
      end else begin
         ack                 <= bus_req;
         avs_waitrequest_out <= ~bus_req; // Kept as a flop so the pin has no gate behind it
      end
   end

   // Read data registered in the request cycle, stands at the ack edge
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         avs_readdata_out <= pcrs_pkg::RD_ZERO;
      end else if (bus_req & avs_read_in) begin
         case (avs_address_in)
            pcrs_pkg::OFS_LOW:  avs_readdata_out <= {24'h00_0000, pc[7:0]};
            pcrs_pkg::OFS_HLAT: avs_readdata_out <= {24'h00_0000, counter_high_latch};
            pcrs_pkg::OFS_ULAT: avs_readdata_out <= {27'h000_0000, counter_upper_latch};
            pcrs_pkg::OFS_PTR:  avs_readdata_out <= {24'h00_0000, stack_full_flag,
                                                     stack_underflow_flag, 1'b0, stack_level}; // R23
            pcrs_pkg::OFS_TOP_ENTRY_LOW: avs_readdata_out <= {24'h00_0000, tos_val[7:0]}; // R15
            pcrs_pkg::OFS_TOP_ENTRY_HIGH: avs_readdata_out <= {24'h00_0000, tos_val[15:8]};
            pcrs_pkg::OFS_TOP_ENTRY_UPPER: avs_readdata_out <= {27'h000_0000, tos_val[20:16]};
            pcrs_pkg::OFS_PCRD: avs_readdata_out <= {11'h000, pc};
            default:            avs_readdata_out <= pcrs_pkg::RD_ZERO;
         endcase
      end
   end

   // ==========================================================
   // Program counter; bit zero forced low everywhere
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         pc <= pcrs_pkg::PC_RESET; // R1
      end else if (overflow_hit & overflow_reset_enable_in) begin
         pc <= pcrs_pkg::PC_RESET; // R18
      end else if (wr_low) begin
         pc <= {counter_upper_latch, counter_high_latch, avs_writedata_in[7:1], 1'b0}; // R2 R3 R4 R6
      end else begin
         case (cmd_in)
            pcrs_pkg::CMD_STEP: pc <= {ret_addr[20:1], 1'b0}; // R6
            pcrs_pkg::CMD_JUMP: pc <= {target_in[20:1], 1'b0}; // R7
            pcrs_pkg::CMD_CALL: pc <= {target_in[20:1], 1'b0}; // R7
            pcrs_pkg::CMD_PUSH: pc <= {ret_addr[20:1], 1'b0};
            pcrs_pkg::CMD_POP:  pc <= {ret_addr[20:1], 1'b0}; // R22
            default: begin
               if (is_pop) begin
                  pc <= {tos_val[20:1], 1'b0}; // R12 R20 R21
               end
            end
         endcase
      end
   end
   assign pc_out = pc;

   // ==========================================================
   // Latches: only bus writes and low-byte reads touch them
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         counter_high_latch  <= 8'h00;
         counter_upper_latch <= 5'h00;
      end else if (rd_low) begin
         counter_high_latch  <= pc[15:8]; // R5
         counter_upper_latch <= pc[20:16];
      end else begin
         if (wr_hlat) begin
            counter_high_latch <= avs_writedata_in[7:0]; // R2
         end
         if (wr_ulat) begin
            counter_upper_latch <= avs_writedata_in[4:0]; // R3
         end
      end
   end

   // ==========================================================
   // Stack pointer
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         stack_level <= pcrs_pkg::LVL_EMPTY; // R13
      end else if (overflow_hit & overflow_reset_enable_in) begin
         stack_level <= pcrs_pkg::LVL_EMPTY; // R18
      end else if (wr_ptr) begin
         stack_level <= avs_writedata_in[4:0]; // R16
      end else if (is_push & ~at_top) begin
         stack_level <= stack_level + 5'h01; // R11 R22
      end else if (is_pop & ~stack_empty) begin
         stack_level <= stack_level - 5'h01; // R12 R20
      end
   end

   // Storage array: push writes the slot after the increment
   always_ff @(posedge clk_in) begin
      if (is_push & ~at_top) begin
         stack_mem[stack_level + 5'h01] <= ret_addr; // R10 R11 R19
      end else if (~stack_empty) begin
         if (wr_tos_l) stack_mem[stack_level][7:0]   <= avs_writedata_in[7:0]; // R15
         if (wr_tos_h) stack_mem[stack_level][15:8]  <= avs_writedata_in[7:0];
         if (wr_tos_u) stack_mem[stack_level][20:16] <= avs_writedata_in[4:0];
      end
   end

   // ==========================================================
   // Flags; hardware set wins over software clear
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         stack_full_flag      <= 1'b0;
         stack_underflow_flag <= 1'b0;
      end else begin
         if (overflow_hit | (is_push & at_top)) begin
            stack_full_flag <= 1'b1; // R17
         end else if (wr_ptr & ~avs_writedata_in[pcrs_pkg::BIT_FULL]) begin
            stack_full_flag <= 1'b0; // R23
         end
         if (is_pop & stack_empty) begin
            stack_underflow_flag <= 1'b1; // R20
         end else if (wr_ptr & ~avs_writedata_in[pcrs_pkg::BIT_UNF]) begin
            stack_underflow_flag <= 1'b0; // R23
         end
      end
   end
   assign stack_full_flag_out      = stack_full_flag;
   assign stack_underflow_flag_out = stack_underflow_flag;

   // Device reset request, one pulse, flags untouched by it
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         overflow_reset_out <= 1'b0;
      end else begin
         overflow_reset_out <= overflow_hit & overflow_reset_enable_in; // R18
      end
   end

   // ==========================================================
   // Checks
   AST_PC_EVEN: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      pc[0] == 1'b0) else $error("counter bit zero set"); // R6
   AST_STEP: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (cmd_in == pcrs_pkg::CMD_STEP) & ~wr_low & ~overflow_hit |=> pc == $past(pc) + 21'h00_0002)
      else $error("step not by two"); // R6
   AST_LOW_WR: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      wr_low & ~overflow_hit |=> pc[20:8] == {$past(counter_upper_latch), $past(counter_high_latch)})
      else $error("latches not copied on low write"); // R4
   AST_LOW_RD: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      rd_low |=> counter_high_latch == $past(pc[15:8]))
      else $error("latch not loaded on low read"); // R5
   AST_CALL_LAT: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (is_push | is_pop) & ~bus_req |=> $stable(counter_high_latch) && $stable(counter_upper_latch))
      else $error("call or return moved latch"); // R9
   AST_PUSH: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      is_push & ~at_top & ~overflow_hit & ~wr_ptr |=> stack_level == $past(stack_level) + 5'h01)
      else $error("push did not increment"); // R11
   AST_UNF: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      is_pop & stack_empty & ~wr_ptr & (cmd_in != pcrs_pkg::CMD_POP)
      |=> stack_underflow_flag && stack_level == 5'h00 && pc == 21'h00_0000)
      else $error("underflow handling wrong"); // R20
   AST_OVF: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      overflow_hit & overflow_reset_enable_in |=> stack_full_flag && stack_level == 5'h00
      ##0 overflow_reset_out) else $error("overflow reset wrong"); // R18
   AST_HOLD: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      is_push & at_top & ~wr_ptr |=> stack_level == 5'h1F)
      else $error("pointer left 31"); // R19
   AST_WAIT: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      bus_req |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
      else $error("bus ack not one cycle"); // R16
   COV_OVF: cover property (@(posedge clk_in) disable iff (!reset_n_in) overflow_reset_out);
   COV_UNF: cover property (@(posedge clk_in) disable iff (!reset_n_in) is_pop & stack_empty);
   COV_RET: cover property (@(posedge clk_in) disable iff (!reset_n_in) is_pop & ~stack_empty);
   COV_LOW: cover property (@(posedge clk_in) disable iff (!reset_n_in) wr_low);
   COV_FULL: cover property (@(posedge clk_in) disable iff (!reset_n_in) is_push & at_top);

   // ==========================================================
   // Counter and latch checks; bus low-byte write outranks commands except an overflow reset
   AST_JUMP: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R7
      (cmd_in == pcrs_pkg::CMD_JUMP) & ~wr_low |=> pc == {$past(target_in[20:1]), 1'b0})
      else $error("jump target not loaded");
   AST_CALL_PC: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R7
      (cmd_in == pcrs_pkg::CMD_CALL) & ~wr_low & ~overflow_hit |=> pc == {$past(target_in[20:1]), 1'b0})
      else $error("call target not loaded");
   AST_PC_IDLE: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R21
      (cmd_in == pcrs_pkg::CMD_NONE) & ~wr_low |=> $stable(pc))
      else $error("counter moved while idle");
   AST_HLAT_WR: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R2
      wr_hlat |=> counter_high_latch == $past(avs_writedata_in[7:0]))
      else $error("high latch write lost");
   AST_ULAT_WR: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R3
      wr_ulat |=> counter_upper_latch == $past(avs_writedata_in[4:0]))
      else $error("upper latch write lost");
   AST_HLAT_QUIET: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R9
      ~wr_hlat & ~rd_low |=> $stable(counter_high_latch))
      else $error("high latch changed without cause");
   AST_ULAT_QUIET: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R9
      ~wr_ulat & ~rd_low |=> $stable(counter_upper_latch))
      else $error("upper latch changed without cause");
   AST_LOW_RD_U: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R5
      rd_low |=> counter_upper_latch == $past(pc[20:16]))
      else $error("upper latch not loaded on low read");

   // ==========================================================
   // Stack checks; pointer writes outrank push and pop except a 31st push with overflow reset enabled
   AST_POP_DEC: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R12
      is_pop & ~stack_empty & ~wr_ptr |=> stack_level == $past(stack_level) - 5'h01)
      else $error("pop did not decrement");
   AST_RET_PC: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R12
      is_pop & (cmd_in != pcrs_pkg::CMD_POP) & ~wr_low |=> pc == {$past(tos_val[20:1]), 1'b0})
      else $error("return did not load top entry");
   AST_PUSH_STORE: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R11
      is_push & ~at_top & ~wr_ptr & ~(overflow_hit & overflow_reset_enable_in)
      |=> tos_val == $past(pc) + pcrs_pkg::PC_STEP)
      else $error("push stored wrong address");
   AST_PTR_WR: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R16
      wr_ptr & ~(overflow_hit & overflow_reset_enable_in) |=> stack_level == $past(avs_writedata_in[4:0]))
      else $error("pointer write lost");
   AST_PTR_IDLE: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R16
      ~wr_ptr & ~is_push & ~is_pop |=> $stable(stack_level))
      else $error("pointer moved without cause");
   AST_ULNK_OFF: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R8
      (cmd_in == pcrs_pkg::CMD_ULNK) & ~ext_set_in & ~wr_low |=> $stable(pc))
      else $error("unlink popped while disabled");
   AST_POP_EMPTY: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R20
      (cmd_in == pcrs_pkg::CMD_POP) & stack_empty & ~wr_ptr
      |=> stack_underflow_flag && stack_level == pcrs_pkg::LVL_EMPTY)
      else $error("empty pop handling wrong");

   // ==========================================================
   // Flag checks; flags are sticky until software clears them
   AST_FULL_HOLD: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R17
      stack_full_flag & ~wr_ptr |=> stack_full_flag)
      else $error("full flag dropped");
   AST_UNF_HOLD: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R20
      stack_underflow_flag & ~wr_ptr |=> stack_underflow_flag)
      else $error("underflow flag dropped");
   AST_FULL_SET: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R19
      overflow_hit & ~overflow_reset_enable_in & ~wr_ptr |=> stack_full_flag && stack_level == pcrs_pkg::LVL_TOP)
      else $error("31st push without reset wrong");
   AST_OVF_PC: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R18
      overflow_hit & overflow_reset_enable_in |=> pc == pcrs_pkg::PC_RESET)
      else $error("overflow reset left counter");

   // ==========================================================
   // Register read checks
   AST_PTR_RD: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R23
      bus_req & avs_read_in & (avs_address_in == pcrs_pkg::OFS_PTR)
      |=> avs_readdata_out[5] == 1'b0 && avs_readdata_out[4:0] == $past(stack_level))
      else $error("pointer read layout wrong");
   AST_TOS_EMPTY: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R14
      bus_req & avs_read_in & (avs_address_in == pcrs_pkg::OFS_TOP_ENTRY_LOW) & stack_empty
      |=> avs_readdata_out == pcrs_pkg::RD_ZERO)
      else $error("empty stack top not zero");
endmodule : pcrs_core
`default_nettype wire

// *** sim/pcrs_seq_model.sv ***
/*
 Sequencer model: issues one command per request, then idles.
 Assumes a single caller and commands taken at each rising edge.
*/
`timescale 1ns/100ps
`default_nettype none
module pcrs_seq_model (
   input  wire logic                       clk_in,
   output var  pcrs_pkg::pcrs_cmd_t        cmd_out,
   output logic [pcrs_pkg::PC_W-1:0]       target_out
);
   // =========================================
   // Idle state
   initial begin
      cmd_out    = pcrs_pkg::CMD_NONE;
      target_out = 21'h0_0000;
   end
   // One command for one taking edge; stale target inverted to hide it
   task automatic issue(input pcrs_pkg::pcrs_cmd_t c, input logic [20:0] t);
      @(posedge clk_in);
      cmd_out    <= c;
      target_out <= t;
      @(posedge clk_in);
      cmd_out    <= pcrs_pkg::CMD_NONE;
      target_out <= ~t;
   endtask : issue
endmodule : pcrs_seq_model
`default_nettype wire

// *** sim/program_counter_return_stack_tb.sv ***
/*
 Bench for the counter and return stack: bus tasks, command sequences.
 Assumes one wait cycle per bus access, bounded by the timeout.
*/
`timescale 1ns/100ps
`default_nettype none
module program_counter_return_stack_tb;
   logic                   clk_in     = 1'b0;
   logic                   reset_n_in = 1'b0;
   logic                   ovr_en     = 1'b1;
   logic                   ext_en     = 1'b0;
   logic [5:0]             addr       = 6'h00;
   logic                   rd         = 1'b0;
   logic                   wr         = 1'b0;
   logic [31:0]            wdata      = 32'h0000_0000;
   logic [31:0]            rdata;
   logic                   waitreq;
   logic [20:0]            pc;
   logic                   pulse;
   logic                   full_flag;
   logic                   unf_flag;
   pcrs_pkg::pcrs_cmd_t    cmd;
   logic [20:0]            target;
   int                     num_errors   = 0;
   int                     total_checks = 0;
   int                     pulses       = 0;
   int                     cycles       = 0;
   // =========================================
   // Clock, design, partner
   initial forever #12.5 clk_in = ~clk_in;
   pcrs_core dut_u (.clk_in(clk_in), .reset_n_in(reset_n_in), .overflow_reset_enable_in(ovr_en),
      .ext_set_in(ext_en), .cmd_in(cmd), .target_in(target), .avs_address_in(addr),
      .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata), .avs_readdata_out(rdata),
      .avs_waitrequest_out(waitreq), .pc_out(pc), .overflow_reset_out(pulse),
      .stack_full_flag_out(full_flag), .stack_underflow_flag_out(unf_flag));
   pcrs_seq_model seq_u (.clk_in(clk_in), .cmd_out(cmd), .target_out(target));
   // Pulse counter and hang guard; the run needs well under 2000 cycles
   always @(posedge clk_in) begin
      cycles++;
      if (pulse === 1'b1) pulses++;
      if (cycles == 5000) begin
         num_errors++;
         conclude();
      end
   end
   // =========================================
   // Tasks
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   // Request held until waitrequest seen low at a rising edge
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk_in);
      addr  <= a;
      wdata <= d;
      wr    <= w;
      rd    <= ~w;
      do begin
         @(posedge clk_in);
      end while (waitreq !== 1'b0);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus
   task automatic wreg(input logic [5:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wreg
   task automatic rchk(input string name, input logic [5:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0000_0000, q);
      check(name, q, exp);
   endtask : rchk
   task automatic cmd_pc(input pcrs_pkg::pcrs_cmd_t c, input logic [20:0] t, input logic [20:0] exp);
      seq_u.issue(c, t);
      @(negedge clk_in);
      check("pc", {11'h000, pc}, {11'h000, exp});
   endtask : cmd_pc
   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : conclude
   // =========================================
   // Test sequence
   initial begin
      repeat (2) @(posedge clk_in);
      reset_n_in <= 1'b1;
      rchk("ptr", pcrs_pkg::OFS_PTR, 32'h0000_0000);
      rchk("unmapped", 6'h20, 32'h0000_0000);
      cmd_pc(pcrs_pkg::CMD_STEP, 21'h0_0000, 21'h0_0002);
      cmd_pc(pcrs_pkg::CMD_JUMP, 21'h1_2345, 21'h1_2344);
      rchk("low", pcrs_pkg::OFS_LOW, 32'h0000_0044);
      rchk("hlat", pcrs_pkg::OFS_HLAT, 32'h0000_0023);
      rchk("ulat", pcrs_pkg::OFS_ULAT, 32'h0000_0001);
      rchk("pc", pcrs_pkg::OFS_PCRD, 32'h0001_2344);
      wreg(pcrs_pkg::OFS_HLAT, 32'h0000_0056);
      wreg(pcrs_pkg::OFS_ULAT, 32'h0000_000A);
      wreg(pcrs_pkg::OFS_LOW, 32'h0000_0079);
      rchk("pc", pcrs_pkg::OFS_PCRD, 32'h000A_5678);
      cmd_pc(pcrs_pkg::CMD_JUMP, 21'h0_0100, 21'h0_0100);
      $display("test counter done");
      cmd_pc(pcrs_pkg::CMD_CALL, 21'h0_2000, 21'h0_2000);
      rchk("ptr", pcrs_pkg::OFS_PTR, 32'h0000_0001);
      rchk("top_entry_low", pcrs_pkg::OFS_TOP_ENTRY_LOW, 32'h0000_0002);
      rchk("top_entry_high", pcrs_pkg::OFS_TOP_ENTRY_HIGH, 32'h0000_0001);
      rchk("top_entry_upper", pcrs_pkg::OFS_TOP_ENTRY_UPPER, 32'h0000_0000);
      rchk("hlat", pcrs_pkg::OFS_HLAT, 32'h0000_0056);
      cmd_pc(pcrs_pkg::CMD_RET, 21'h0_0000, 21'h0_0102);
      rchk("ptr", pcrs_pkg::OFS_PTR, 32'h0000_0000);
      cmd_pc(pcrs_pkg::CMD_RET, 21'h0_0000, 21'h0_0000);
      rchk("ptr", pcrs_pkg::OFS_PTR, 32'h0000_0040);
      check("unf_out", {31'h0000_0000, unf_flag}, 32'h0000_0001);
      rchk("hlat", pcrs_pkg::OFS_HLAT, 32'h0000_0056);
      wreg(pcrs_pkg::OFS_PTR, 32'h0000_0000);
      rchk("ptr", pcrs_pkg::OFS_PTR, 32'h0000_0000);
      cmd_pc(pcrs_pkg::CMD_CALL, 21'h0_0300, 21'h0_0300);
      cmd_pc(pcrs_pkg::CMD_ULNK, 21'h0_0000, 21'h0_0300);
      @(posedge clk_in);
      ext_en <= 1'b1;
      cmd_pc(pcrs_pkg::CMD_ULNK, 21'h0_0000, 21'h0_0002);
      $display("test call return done");
      cmd_pc(pcrs_pkg::CMD_PUSH, 21'h0_0000, 21'h0_0004);
      rchk("top_entry_low", pcrs_pkg::OFS_TOP_ENTRY_LOW, 32'h0000_0004);
      wreg(pcrs_pkg::OFS_TOP_ENTRY_LOW, 32'h0000_0034);
      rchk("top_entry_low", pcrs_pkg::OFS_TOP_ENTRY_LOW, 32'h0000_0034);
      cmd_pc(pcrs_pkg::CMD_PUSH, 21'h0_0000, 21'h0_0006);
      cmd_pc(pcrs_pkg::CMD_POP, 21'h0_0000, 21'h0_0008);
      rchk("top_entry_low", pcrs_pkg::OFS_TOP_ENTRY_LOW, 32'h0000_0034);
      wreg(pcrs_pkg::OFS_PTR, 32'h0000_00FF);
      rchk("ptr", pcrs_pkg::OFS_PTR, 32'h0000_001F);
      $display("test push pop done");
      @(posedge clk_in);
      ovr_en <= 1'b0;
      wreg(pcrs_pkg::OFS_PTR, 32'h0000_0000);
      for (int i = 0; i < 31; i++) seq_u.issue(pcrs_pkg::CMD_CALL, 21'h0_0400);
      rchk("ptr", pcrs_pkg::OFS_PTR, 32'h0000_009F);
      check("full_out", {31'h0000_0000, full_flag}, 32'h0000_0001);
      cmd_pc(pcrs_pkg::CMD_JUMP, 21'h0_01F0, 21'h0_01F0);
      cmd_pc(pcrs_pkg::CMD_CALL, 21'h0_0410, 21'h0_0410);
      rchk("ptr", pcrs_pkg::OFS_PTR, 32'h0000_009F);
      rchk("top_entry_low", pcrs_pkg::OFS_TOP_ENTRY_LOW, 32'h0000_0002);
      wreg(pcrs_pkg::OFS_PTR, 32'h0000_001E);
      rchk("ptr", pcrs_pkg::OFS_PTR, 32'h0000_001E);
      @(posedge clk_in);
      ovr_en <= 1'b1;
      cmd_pc(pcrs_pkg::CMD_CALL, 21'h0_0500, 21'h0_0000);
      repeat (3) @(posedge clk_in);
      check("pulses", pulses, 32'h0000_0001);
      rchk("ptr", pcrs_pkg::OFS_PTR, 32'h0000_0080);
      wreg(pcrs_pkg::OFS_PTR, 32'h0000_001F);
      rchk("top_entry_low", pcrs_pkg::OFS_TOP_ENTRY_LOW, 32'h0000_0012);
      $display("test overflow done");
      @(posedge clk_in);
      reset_n_in <= 1'b0;
      @(posedge clk_in);
      reset_n_in <= 1'b1;
      rchk("ptr", pcrs_pkg::OFS_PTR, 32'h0000_0000);
      $display("test reset done");
      conclude();
   end
endmodule : program_counter_return_stack_tb
`default_nettype wire
